/* common/dcl_defs.svh */
// Offsets, field positions, reset values and counts of the config loader.
// Included by the package, by the device end and by the test.
`ifndef DCL_DEFS_SVH
`define DCL_DEFS_SVH

`define DCL_NUM_REGS 10
`define DCL_LAST_IDX 4'h9
// Loaded configuration bytes
`define DCL_OFS_FAIL_SAFE_OUTPUT_PIN_SEL 8'ha0
`define DCL_OFS_BUS_CFG 8'ha1
`define DCL_OFS_CTRL1 8'ha2
`define DCL_OFS_CTRL2 8'ha3
`define DCL_OFS_CTRL3 8'ha4
`define DCL_OFS_BUCK_UVB 8'hdd
`define DCL_OFS_LIN_UVB 8'hde
`define DCL_OFS_BUCK_ILB 8'hdf
`define DCL_OFS_LIN_ILB 8'he0
`define DCL_OFS_DBG_REF 8'he3
// Page select and fault flags, reachable on every page
`define DCL_OFS_PAGE 8'h03
`define DCL_OFS_FLAGS 8'h04
`define DCL_PAGE_FUNC 3'h0
`define DCL_PAGE_MIRROR 3'h1
// Fault flag bits
`define DCL_FLG_TRIM 0
`define DCL_FLG_FUSE 1
`define DCL_FLG_STEST 2
// Fields of the loaded bytes
`define DCL_BUS_CRC_BIT 7
`define DCL_BUS_SECURE_BIT 6
`define DCL_LOWPOWER_OFF_DEFAULT_BIT_BIT 7
`define DCL_BUS_ADDR_BASE 7'h08
`define DCL_TRIAL_ADDR 7'h08
// Hardwired defaults, remaining bytes zero
`define DCL_HW_FAIL_SAFE_OUTPUT_PIN_SEL 8'h00
`define DCL_HW_BUS_CFG 8'h00
`define DCL_HW_CTRL1 8'h02
`define DCL_HW_CTRL2 8'h05
`define DCL_HW_CTRL3 8'h01
`define DCL_HW_OTHER 8'h00

`endif

/* common/dcl_pkg.sv */
// Types shared by both ends of the default config loader.
// Expects dcl_defs.svh on the include path.
`include "dcl_defs.svh"

package dcl_pkg;

  typedef logic [7:0] dcl_byte_t;
  typedef logic [`DCL_NUM_REGS-1:0][7:0] dcl_bank_t;

  typedef enum logic [2:0] {
    DCL_OFF, DCL_TRIM, DCL_FUSE, DCL_LOAD, DCL_TEST, DCL_QUIET, DCL_ON
  } dcl_state_e;

  typedef enum logic [1:0] {DCL_H_IDLE, DCL_H_WAIT, DCL_H_DROP} dcl_hstate_e;

  typedef struct packed {
    dcl_state_e st;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic hw_src;
    logic [3:0] idx;
    dcl_bank_t func;
    dcl_bank_t mirror;
    logic [2:0] page;
    logic [2:0] flags;
    logic ack;
    logic err;
    dcl_byte_t rdata;
    logic quiet;
    logic seq_en;
    logic wdog_en;
    logic crc_en;
    logic secure_en;
    logic limited;
    logic fuse_burn;
  } dcl_dev_s;

  typedef struct packed {
    dcl_hstate_e st;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic req;
    logic we;
    logic [6:0] dev_addr;
    dcl_byte_t addr;
    dcl_byte_t wdata;
    logic cmd_ready;
    logic rsp_valid;
    logic rsp_err;
    dcl_byte_t rsp_rdata;
    logic trial_pin;
    logic pwr_pin;
    logic burn;
  } dcl_host_s;

endpackage

/* common/dcl_if.sv */
// Link between the loader device and its host controller.
// Request fields are held stable while req is high (bundled data).
`timescale 1ns/1ns

interface dcl_if;
  logic trial_config_enable_pin;
  logic power_up_event;
  logic burn_req;
  logic req;
  logic we;
  logic [6:0] dev_addr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic err;
  logic [7:0] rdata;
  logic quiescent_off_state;

  modport device (
    input trial_config_enable_pin, power_up_event, burn_req, req, we,
    input dev_addr, addr, wdata,
    output ack, err, rdata, quiescent_off_state
  );
  modport host (
    output trial_config_enable_pin, power_up_event, burn_req, req, we,
    output dev_addr, addr, wdata,
    input ack, err, rdata, quiescent_off_state
  );
endinterface

/* hw/dcl_device.sv */
// Loader device end: fuse/hardwired default loading, fault flags, paging.
// Link inputs are asynchronous pins; fuse, trim and self-test inputs come
// from logic on sys_clk.
`timescale 1ns/1ns
`include "dcl_defs.svh"

// Behaviour
// - Source pin low: defaults from mirror registers
// - Source pin high: hardwired default every reload
// - Fuse mode: fuses to mirror on supply rise
// - Fuse mode: mirror then copied to functional
// - Hardwired: no trial mode, hardwired defaults only
// - Fuse mode faults block power-up; write 1 clears
// - Hardwired faults block power-up; write 0 clears
// - Flags writable only with enable pin high
// - Trial mode: skip low-power bit, go quiescent
// - Trial/debug: self-test flag shows test result
// - Trial mode: plain transfers at address 0x08
// - Trial mode disables all watchdog monitoring
// - Page 1 mirror only in trial mode
// - Mirror preloaded from fuses, host may rewrite
// - Power-up with pin high gives limited function
// - Supply loss clears the mirror registers
// - Fuse burning only in trial and quiescent
// - Hardwired still loads trim, flags trim failure
// - Hardwired keeps fuse fault flag at zero
// - Hardwired plus pin high: debug, go quiescent
// - Hardwired fail-safe byte is all zero
module dcl_device
  import dcl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  dcl_if.device link,
  input wire logic config_source_pin,
  input wire logic supply_above_input_undervolt_detect,
  input wire logic trim_fail,
  input wire logic [7:0] fuse_data,
  input wire logic fuse_fail,
  input wire logic selftest_fail,
  output logic [3:0] fuse_index,
  output logic fuse_burn,
  output logic seq_enable,
  output logic watchdog_enable,
  output logic crc_enable,
  output logic secure_write_enable,
  output logic limited_function
);
  import dcl_pkg::*;

  localparam int S_TRIAL = 0;
  localparam int S_PWR = 1;
  localparam int S_UV = 2;
  localparam int S_REQ = 3;
  localparam int S_BURN = 4;
  localparam int S_SRC = 5;

  dcl_dev_s s;
  dcl_dev_s next_s;

  // Register index of an offset; bit 4 flags a hit
  function automatic logic [4:0] reg_index(input logic [7:0] ofs);
    case (ofs)
      `DCL_OFS_FAIL_SAFE_OUTPUT_PIN_SEL: reg_index = 5'h10;
      `DCL_OFS_BUS_CFG: reg_index = 5'h11;
      `DCL_OFS_CTRL1: reg_index = 5'h12;
      `DCL_OFS_CTRL2: reg_index = 5'h13;
      `DCL_OFS_CTRL3: reg_index = 5'h14;
      `DCL_OFS_BUCK_UVB: reg_index = 5'h15;
      `DCL_OFS_LIN_UVB: reg_index = 5'h16;
      `DCL_OFS_BUCK_ILB: reg_index = 5'h17;
      `DCL_OFS_LIN_ILB: reg_index = 5'h18;
      `DCL_OFS_DBG_REF: reg_index = 5'h19;
      default: reg_index = 5'h00;
    endcase
  endfunction

  function automatic dcl_byte_t hw_default(input logic [3:0] i);
    case (i)
      4'h0: hw_default = `DCL_HW_FAIL_SAFE_OUTPUT_PIN_SEL;
      4'h1: hw_default = `DCL_HW_BUS_CFG;
      4'h2: hw_default = `DCL_HW_CTRL1;
      4'h3: hw_default = `DCL_HW_CTRL2;
      4'h4: hw_default = `DCL_HW_CTRL3;
      default: hw_default = `DCL_HW_OTHER;
    endcase
  endfunction

  logic pin_trial;
  logic trial_md;
  logic debug_md;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [4:0] hit;
  logic [6:0] my_addr;
  logic page_ok;

  assign pin_trial = s.sync2[S_TRIAL];
  assign trial_md = pin_trial & ~s.hw_src;
  assign debug_md = pin_trial & s.hw_src;

  always_comb begin
    next_s = s;
    flag_set = 3'h0;
    flag_clr = 3'h0;
    hit = reg_index(link.addr);
    my_addr = trial_md ? `DCL_TRIAL_ADDR :
      (`DCL_BUS_ADDR_BASE | {4'h0, s.func[1][2:0]});
    page_ok = (s.page == `DCL_PAGE_FUNC) ||
      (trial_md && s.page == `DCL_PAGE_MIRROR);
    next_s.sync1 = {config_source_pin, link.burn_req, link.req,
      supply_above_input_undervolt_detect, link.power_up_event, link.trial_config_enable_pin};
    next_s.sync2 = s.sync1;
    next_s.fuse_burn = 1'b0;

    case (s.st)
      DCL_OFF: begin
        next_s.idx = 4'h0;
        if (s.sync2[S_UV]) begin
          next_s.hw_src = s.sync2[S_SRC];
          next_s.st = DCL_TRIM;
        end
      end
      DCL_TRIM: begin
        flag_set[`DCL_FLG_TRIM] = trim_fail;
        next_s.st = s.hw_src ? DCL_LOAD : DCL_FUSE;
      end
      DCL_FUSE: begin
        next_s.mirror[s.idx] = fuse_data;
        flag_set[`DCL_FLG_FUSE] = fuse_fail;
        next_s.idx = s.idx + 4'h1;
        if (s.idx == `DCL_LAST_IDX) begin
          next_s.idx = 4'h0;
          next_s.st = DCL_LOAD;
        end
      end
      DCL_LOAD: begin
        next_s.func[s.idx] = s.hw_src ? hw_default(s.idx) :
          s.mirror[s.idx];
        next_s.idx = s.idx + 4'h1;
        if (s.idx == `DCL_LAST_IDX) begin
          next_s.idx = 4'h0;
          next_s.st = DCL_TEST;
        end
      end
      DCL_TEST: begin
        flag_set[`DCL_FLG_STEST] = selftest_fail;
        flag_clr[`DCL_FLG_STEST] = ~selftest_fail;
        if (pin_trial || selftest_fail || (s.flags != 3'h0) ||
            s.func[2][`DCL_LOWPOWER_OFF_DEFAULT_BIT_BIT]) begin
          next_s.st = DCL_QUIET;
        end else begin
          next_s.st = DCL_ON;
          next_s.limited = 1'b0;
        end
      end
      DCL_QUIET: begin
        if (s.sync2[S_PWR] && s.flags == 3'h0) begin
          next_s.st = DCL_ON;
          next_s.limited = pin_trial;
        end
        if (s.sync2[S_BURN] && trial_md) begin
          next_s.fuse_burn = 1'b1;
        end
      end
      DCL_ON: begin
        if (!s.sync2[S_PWR]) begin
          next_s.st = DCL_QUIET;
        end
      end
      default: next_s.st = DCL_OFF;
    endcase

    // Register access, four-phase handshake
    if (s.sync2[S_REQ] && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.err = 1'b0;
      next_s.rdata = 8'h00;
      if (link.dev_addr != my_addr) begin
        next_s.err = 1'b1;
      end else if (link.addr == `DCL_OFS_PAGE) begin
        next_s.rdata = {5'h00, s.page};
        if (link.we) begin
          if (link.wdata[2:0] == `DCL_PAGE_FUNC ||
              (trial_md && link.wdata[2:0] == `DCL_PAGE_MIRROR)) begin
            next_s.page = link.wdata[2:0];
          end else begin
            next_s.err = 1'b1;
          end
        end
      end else if (link.addr == `DCL_OFS_FLAGS) begin
        next_s.rdata = {5'h00, s.flags};
        if (link.we) begin
          if (trial_md && s.st == DCL_QUIET) begin
            flag_clr = flag_clr | link.wdata[2:0];
          end else if (debug_md) begin
            flag_clr = flag_clr | ~link.wdata[2:0];
          end else begin
            next_s.err = 1'b1;
          end
        end
      end else if (!page_ok || !hit[4]) begin
        next_s.err = 1'b1;
      end else if (s.page == `DCL_PAGE_MIRROR) begin
        next_s.rdata = s.mirror[hit[3:0]];
        if (link.we) begin
          next_s.mirror[hit[3:0]] = link.wdata;
        end
      end else begin
        next_s.rdata = s.func[hit[3:0]];
        if (link.we) begin
          next_s.func[hit[3:0]] = link.wdata;
        end
      end
      next_s.rdata = next_s.err ? 8'h00 : next_s.rdata;
    end else if (!s.sync2[S_REQ] && s.ack) begin
      next_s.ack = 1'b0;
    end

    // Set wins over clear
    next_s.flags = (s.flags & ~flag_clr) | flag_set;
    if (s.hw_src) begin
      next_s.flags[`DCL_FLG_FUSE] = 1'b0;
    end
    if (!trial_md) begin
      if (s.page != `DCL_PAGE_FUNC) begin
        next_s.page = `DCL_PAGE_FUNC;
      end
    end

    // Supply loss aborts the power sequence and clears the mirror
    if (!s.sync2[S_UV]) begin
      next_s.st = DCL_OFF;
      next_s.mirror = '0;
      next_s.limited = 1'b0;
    end

    next_s.quiet = (next_s.st == DCL_QUIET);
    next_s.seq_en = (next_s.st == DCL_ON);
    next_s.wdog_en = next_s.seq_en & ~trial_md & ~next_s.limited;
    next_s.crc_en = next_s.seq_en & ~trial_md & ~next_s.limited &
      next_s.func[1][`DCL_BUS_CRC_BIT];
    next_s.secure_en = next_s.seq_en & ~trial_md & ~next_s.limited &
      next_s.func[1][`DCL_BUS_SECURE_BIT];
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.ack = s.ack;
  assign link.err = s.err;
  assign link.rdata = s.rdata;
  assign link.quiescent_off_state = s.quiet;
  assign fuse_index = s.idx;
  assign fuse_burn = s.fuse_burn;
  assign seq_enable = s.seq_en;
  assign watchdog_enable = s.wdog_en;
  assign crc_enable = s.crc_en;
  assign secure_write_enable = s.secure_en;
  assign limited_function = s.limited;

endmodule // dcl_device

/* hw/dcl_host.sv */
// Host end of the loader link: register commands, mode and power pins.
// Ack and quiet state from the device are asynchronous and synchronised here; err and rdata are sampled with ack.
`timescale 1ns/1ns

module dcl_host
  import dcl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  dcl_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [6:0] cmd_dev_addr,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic want_trial,
  input wire logic want_power,
  input wire logic full_function,
  input wire logic burn_cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [7:0] rsp_rdata
);
  import dcl_pkg::*;

  dcl_host_s s;
  dcl_host_s next_s;
  logic ack_s;
  logic quiet_s;

  assign ack_s = s.sync2[0];
  assign quiet_s = s.sync2[1];

  always_comb begin
    next_s = s;
    next_s.sync1 = {link.quiescent_off_state, link.ack};
    next_s.sync2 = s.sync1;
    next_s.rsp_valid = 1'b0;
    // Pin low at power-up when full function is wanted
    next_s.trial_pin = want_trial & ~(want_power & full_function);
    next_s.pwr_pin = want_power;
    // Burning only in trial mode while quiescent
    next_s.burn = burn_cmd & s.trial_pin & quiet_s;
    case (s.st)
      DCL_H_IDLE: begin
        next_s.cmd_ready = 1'b1;
        if (cmd_valid && s.cmd_ready) begin
          next_s.cmd_ready = 1'b0;
          next_s.req = 1'b1;
          next_s.we = cmd_write;
          next_s.dev_addr = cmd_dev_addr;
          next_s.addr = cmd_addr;
          next_s.wdata = cmd_wdata;
          next_s.st = DCL_H_WAIT;
        end
      end
      DCL_H_WAIT: begin
        if (ack_s) begin
          next_s.req = 1'b0;
          next_s.rsp_valid = 1'b1;
          next_s.rsp_err = link.err;
          next_s.rsp_rdata = link.rdata;
          next_s.st = DCL_H_DROP;
        end
      end
      DCL_H_DROP: begin
        if (!ack_s) begin
          next_s.cmd_ready = 1'b1;
          next_s.st = DCL_H_IDLE;
        end
      end
      default: next_s.st = DCL_H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.trial_config_enable_pin = s.trial_pin;
  assign link.power_up_event = s.pwr_pin;
  assign link.burn_req = s.burn;
  assign link.req = s.req;
  assign link.we = s.we;
  assign link.dev_addr = s.dev_addr;
  assign link.addr = s.addr;
  assign link.wdata = s.wdata;
  assign cmd_ready = s.cmd_ready;
  assign rsp_valid = s.rsp_valid;
  assign rsp_err = s.rsp_err;
  assign rsp_rdata = s.rsp_rdata;

endmodule // dcl_host

/* dv/dcl_link_checker.sv */
// Checker of the loader link between the device and host ends.
// Instantiated beside the link interface; sees its signals only.
`timescale 1ns/1ns

module dcl_link_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic trial_config_enable_pin,
  input wire logic power_up_event,
  input wire logic burn_req,
  input wire logic req,
  input wire logic we,
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [7:0] rdata,
  input wire logic quiescent_off_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_ack_after_req: assert property ($rose(ack) |-> req && $past(req, 3))
    else $error("ack rose without a held request");
  a_ack_holds: assert property (ack && req |=> ack)
    else $error("ack dropped while request held");
  a_ack_release: assert property ($fell(req) |-> ##[2:4] !ack)
    else $error("ack not released after request");
  a_idle_no_ack: assert property (!req && !ack |=> !ack [*2])
    else $error("ack without request");
  a_err_zero_data: assert property ($rose(ack) && err |-> rdata == 8'h00)
    else $error("read data not zero on refusal");
  a_trial_addr_only: assert property (
    $rose(ack) && trial_config_enable_pin
    && $past(trial_config_enable_pin, 4) && dev_addr != 7'h08 |-> err)
    else $error("foreign address answered in trial mode");
  a_page_refused: assert property (
    $rose(ack) && !trial_config_enable_pin
    && !$past(trial_config_enable_pin, 4) && we && addr == 8'h03
    && wdata != 8'h00 |-> err)
    else $error("extended page taken outside trial mode");
  a_flag_write_locked: assert property (
    $rose(ack) && !trial_config_enable_pin
    && !$past(trial_config_enable_pin, 4) && we && addr == 8'h04 |-> err)
    else $error("fault flags written with enable pin low");

  c_refused: cover property ($rose(ack) && err);
  c_read_ok: cover property ($rose(ack) && !err && !we);
  c_quiet: cover property ($rose(quiescent_off_state));
  c_trial_power: cover property ($rose(power_up_event)
    && trial_config_enable_pin && !burn_req);
endmodule // dcl_link_checker

/* dv/default_config_loader_test.sv */
// Self-checking bench of the config loader: both ends joined by the link.
// Fuse bytes come from a table here; no other agents are present.
`timescale 1ns/1ns
`include "dcl_defs.svh"

`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
  bad_count++; $display("[ERR] %0t %s", $time, m); end end

module default_config_loader_test;
  import dcl_pkg::*;
  logic sys_clk, rst_b, src, sup, trim_f, fuse_f, st_f;
  logic cv, cw, wt, wp, ff, crdy, rv, re, seq_en, wd_en, crc_en, lim;
  logic bc, fb, sw_en;
  logic [6:0] cda;
  logic [7:0] ca, cd, fdat, rd;
  logic [3:0] fidx;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] ofs [10] = '{`DCL_OFS_FAIL_SAFE_OUTPUT_PIN_SEL, `DCL_OFS_BUS_CFG,
    `DCL_OFS_CTRL1, `DCL_OFS_CTRL2, `DCL_OFS_CTRL3, `DCL_OFS_BUCK_UVB,
    `DCL_OFS_LIN_UVB, `DCL_OFS_BUCK_ILB, `DCL_OFS_LIN_ILB, `DCL_OFS_DBG_REF};

  // Bus config 0xc3: address 0x0b, crc and secure write on
  function automatic logic [7:0] fv(input logic [3:0] i);
    return (i == 4'h1) ? 8'hc3 : (i == 4'h2) ? 8'h02 : {4'h6, i};
  endfunction
  function automatic logic [7:0] hw(input logic [3:0] i);
    return (i == 4'h2) ? 8'h02 : (i == 4'h3) ? 8'h05 :
      (i == 4'h4) ? 8'h01 : 8'h00;
  endfunction

  assign fdat = fv(fidx);
  dcl_if dcl_if_inst();
  dcl_device dcl_device_inst(.sys_clk, .rst_b, .link(dcl_if_inst),
    .config_source_pin(src), .supply_above_input_undervolt_detect(sup), .trim_fail(trim_f),
    .fuse_data(fdat), .fuse_fail(fuse_f), .selftest_fail(st_f),
    .fuse_index(fidx), .fuse_burn(fb), .seq_enable(seq_en),
    .watchdog_enable(wd_en), .crc_enable(crc_en),
    .secure_write_enable(sw_en), .limited_function(lim));
  dcl_host dcl_host_inst(.sys_clk, .rst_b, .link(dcl_if_inst),
    .cmd_valid(cv), .cmd_write(cw), .cmd_dev_addr(cda), .cmd_addr(ca),
    .cmd_wdata(cd), .want_trial(wt), .want_power(wp), .full_function(ff),
    .burn_cmd(bc), .cmd_ready(crdy), .rsp_valid(rv), .rsp_err(re),
    .rsp_rdata(rd));
  dcl_link_checker dcl_link_checker_inst(.sys_clk, .rst_b,
    .trial_config_enable_pin(dcl_if_inst.trial_config_enable_pin),
    .power_up_event(dcl_if_inst.power_up_event),
    .burn_req(dcl_if_inst.burn_req), .req(dcl_if_inst.req),
    .we(dcl_if_inst.we), .dev_addr(dcl_if_inst.dev_addr),
    .addr(dcl_if_inst.addr), .wdata(dcl_if_inst.wdata),
    .ack(dcl_if_inst.ack), .err(dcl_if_inst.err),
    .rdata(dcl_if_inst.rdata),
    .quiescent_off_state(dcl_if_inst.quiescent_off_state));

  // One register access; checks refusal and, for reads, the data
  task automatic acc(input logic w, input logic [6:0] da,
      input logic [7:0] a, input logic [7:0] d, input logic e,
      input logic [7:0] x);
    int n;
    n = 0;
    while (crdy !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cv <= 1'b1;
    cw <= w;
    cda <= da;
    ca <= a;
    cd <= d;
    @(posedge sys_clk);
    cv <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (rv !== 1'b1 && n < 100);
    `CHK(rv, 1'b1, "no response")
    `CHK(re, e, "refusal flag")
    if (!w) `CHK(rd, x, "read data")
  endtask

  // Waits for quiet state (q=1) or sequencing enable (q=0) to reach v
  task automatic wait_for(input bit q, input logic v);
    int n;
    n = 0;
    while (((q ? dcl_if_inst.quiescent_off_state : seq_en) !== v)
        && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(n < 300, 1'b1, "state not reached")
  endtask

  task automatic fuse_boot();
    wait_for(1'b0, 1'b1);
    `CHK(wd_en, 1'b1, "watchdog off in normal run")
    `CHK(crc_en, 1'b1, "crc off in normal run")
    `CHK(sw_en, 1'b1, "secure write off in normal run")
    @(posedge sys_clk);
    bc <= 1'b1;
    repeat (6) @(negedge sys_clk);
    `CHK(fb, 1'b0, "fuse burn outside trial mode")
    @(posedge sys_clk);
    bc <= 1'b0;
    for (int i = 0; i < 10; i++)
      acc(1'b0, 7'h0b, ofs[i], 8'h00, 1'b0, fv(i[3:0]));
    acc(1'b0, 7'h08, ofs[0], 8'h00, 1'b1, 8'h00);
    acc(1'b1, 7'h0b, `DCL_OFS_PAGE, 8'h01, 1'b1, 8'h00);
    acc(1'b1, 7'h0b, `DCL_OFS_FLAGS, 8'h07, 1'b1, 8'h00);
    acc(1'b0, 7'h0b, `DCL_OFS_FLAGS, 8'h00, 1'b0, 8'h00);
  endtask

  task automatic trial_mode();
    @(posedge sys_clk);
    wp <= 1'b0;
    ff <= 1'b0;
    wait_for(1'b1, 1'b1);
    @(posedge sys_clk);
    wt <= 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK(wd_en, 1'b0, "watchdog still on")
    `CHK(crc_en, 1'b0, "crc still on")
    @(posedge sys_clk);
    bc <= 1'b1;
    repeat (6) @(negedge sys_clk);
    `CHK(fb, 1'b1, "fuse burn refused in trial mode")
    @(posedge sys_clk);
    bc <= 1'b0;
    repeat (6) @(negedge sys_clk);
    `CHK(fb, 1'b0, "fuse burn without request")
    acc(1'b0, 7'h0b, ofs[0], 8'h00, 1'b1, 8'h00);
    acc(1'b1, 7'h08, `DCL_OFS_PAGE, 8'h01, 1'b0, 8'h00);
    acc(1'b1, 7'h08, ofs[0], 8'h5a, 1'b0, 8'h00);
    acc(1'b0, 7'h08, ofs[0], 8'h00, 1'b0, 8'h5a);
    @(posedge sys_clk);
    sup <= 1'b0;
    wait_for(1'b1, 1'b0);
    @(posedge sys_clk);
    wp <= 1'b1;
    st_f <= 1'b1;
    sup <= 1'b1;
    wait_for(1'b1, 1'b1);
    acc(1'b0, 7'h08, `DCL_OFS_FLAGS, 8'h00, 1'b0, 8'h04);
    acc(1'b1, 7'h08, `DCL_OFS_PAGE, 8'h01, 1'b0, 8'h00);
    acc(1'b0, 7'h08, ofs[0], 8'h00, 1'b0, fv(4'h0));
    `CHK(seq_en, 1'b0, "power-up not blocked")
    @(posedge sys_clk);
    st_f <= 1'b0;
    acc(1'b1, 7'h08, `DCL_OFS_FLAGS, 8'h04, 1'b0, 8'h00);
    wait_for(1'b0, 1'b1);
    `CHK(lim, 1'b1, "full function with pin high")
    `CHK(wd_en, 1'b0, "watchdog on with limited function")
    `CHK(crc_en, 1'b0, "crc on with limited function")
    `CHK(sw_en, 1'b0, "secure write on in trial mode")
  endtask

  task automatic hardwired();
    @(posedge sys_clk);
    sup <= 1'b0;
    wait_for(1'b0, 1'b0);
    @(posedge sys_clk);
    src <= 1'b1;
    trim_f <= 1'b1;
    fuse_f <= 1'b1;
    sup <= 1'b1;
    wait_for(1'b1, 1'b1);
    acc(1'b0, 7'h08, `DCL_OFS_FLAGS, 8'h00, 1'b0, 8'h01);
    for (int i = 0; i < 10; i++)
      acc(1'b0, 7'h08, ofs[i], 8'h00, 1'b0, hw(i[3:0]));
    acc(1'b1, 7'h08, `DCL_OFS_PAGE, 8'h01, 1'b1, 8'h00);
    `CHK(seq_en, 1'b0, "power-up not blocked")
    @(posedge sys_clk);
    trim_f <= 1'b0;
    acc(1'b1, 7'h08, `DCL_OFS_FLAGS, 8'h00, 1'b0, 8'h00);
    wait_for(1'b0, 1'b1);
  endtask

  task automatic summarize();
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    rst_b = 1'b0;
    {src, trim_f, fuse_f, st_f, cv, cw, wt, bc} = 8'h00;
    {sup, wp, ff} = 3'h7;
    cda = 7'h00;
    ca = 8'h00;
    cd = 8'h00;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    fuse_boot();
    trial_mode();
    hardwired();
    summarize();
  end
endmodule // default_config_loader_test
